/* File: rcp_top.sv */
// pin control logic of the remote control transceiver
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`include "rcp_map.svh"
module rcp_top
  import rcp_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  // pins
  input  wire logic        reset_pin_n,
  input  wire logic        sleep_req_n,
  input  wire logic        low_group_direction,
  input  wire logic        high_group_direction,
  input  wire logic        toggle_sel,
  input  wire logic        ack_en,
  input  wire logic        bind_req,
  input  wire logic [7:0]  status_lines_in,
  output logic      [7:0]  status_lines_out,
  output logic      [7:0]  status_lines_oe,
  output logic             receive_amp_enable,
  output logic             transmit_amp_enable,
  output logic             activity_indicator,
  output logic             reply_received,
  output logic             reply_request,
  output logic             bind_start,
  output logic             factory_default,
  // radio core side
  input  wire logic [8:0]  rx_cmd,
  input  wire logic        ack_match
);
  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  localparam int SW = 15;
  logic [SW-1:0] pins_s;
  rcp_straps_t   straps;
  rcp_cmd_t      cmd;
  logic [7:0]    lines_s;
  logic          bind_s;
  logic          sleep_s;
  logic          rst_s;
  rcp_sync #(.W(SW)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({reset_pin_n, sleep_req_n, low_group_direction,
               high_group_direction, toggle_sel, ack_en, bind_req,
               status_lines_in}),
    .q       (pins_s)
  );
  assign rst_s   = pins_s[14];
  assign sleep_s = pins_s[13];
  assign straps  = rcp_straps_t'({pins_s[9], pins_s[10], pins_s[12],
                                  pins_s[11]});
  assign bind_s  = pins_s[8];
  assign lines_s = pins_s[7:0];
  assign cmd     = rcp_cmd_t'(rx_cmd);
  // -------------------------------------------------------------
  // run enable from reset pin and sleep request
  // -------------------------------------------------------------
  logic run;
  assign run = rst_s & sleep_s;
  // -------------------------------------------------------------
  // direction and outputs
  // -------------------------------------------------------------
  logic [7:0] out_mask;
  logic [7:0] in_mask;
  logic [7:0] out_r;
  logic [7:0] out_nxt;
  logic [7:0] hit;
  assign out_mask = {{4{~straps.high_group_direction}},
                     {4{~straps.low_group_direction}}};
  assign in_mask  = ~out_mask;
  assign hit      = cmd.valid ? (cmd.lines & out_mask) : 8'h00;
  assign out_nxt  = !run ? 8'h00 :
                    straps.toggle_sel ? (out_r ^ hit) & out_mask
                    : (cmd.valid ? hit : out_r & out_mask);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) out_r <= 8'h00;
    else          out_r <= out_nxt;
  end
  assign status_lines_out = out_r;
  assign status_lines_oe  = run ? out_mask : 8'h00;
  // -------------------------------------------------------------
  // momentary release: outputs hold when commands stop and drop on a valid frame with zero lines
  // -------------------------------------------------------------
  // handled above: in momentary mode a gap frame from the core with
  // valid set and zero lines clears the output
  // -------------------------------------------------------------
  // millisecond tick
  // -------------------------------------------------------------
  logic [15:0] div_r;
  logic        tick;
  assign tick = (div_r == 16'(`RCP_TICK_DIV - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)  div_r <= 16'h0000;
    else if (tick) div_r <= 16'h0000;
    else           div_r <= div_r + 16'h0001;
  end
  // -------------------------------------------------------------
  // reply received hold
  // -------------------------------------------------------------
  logic [7:0] ack_cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ack_cnt_r <= 8'h00;
    else if (!run)
      ack_cnt_r <= 8'h00;
    else if (ack_match)
      ack_cnt_r <= 8'(`RCP_ACK_TICKS);
    else if (tick && ack_cnt_r != 8'h00)
      ack_cnt_r <= ack_cnt_r - 8'h01;
  end
  assign reply_received = (ack_cnt_r != 8'h00);
  // -------------------------------------------------------------
  // acknowledgement request
  // -------------------------------------------------------------
  logic reply_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) reply_r <= 1'b0;
    else          reply_r <= run & cmd.valid & straps.ack_en;
  end
  assign reply_request = reply_r;
  // -------------------------------------------------------------
  // control register and amp enables
  // -------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic        rx_r;
  logic        tx_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_r <= 1'b0;
      tx_r <= 1'b0;
    end else begin
      rx_r <= run & ctrl_r[`RCP_CTRL_RX_BIT];
      tx_r <= run & ctrl_r[`RCP_CTRL_TX_BIT];
    end
  end
  assign receive_amp_enable  = rx_r;
  assign transmit_amp_enable = tx_r;
  // -------------------------------------------------------------
  // bind request and factory default sequence
  // -------------------------------------------------------------
  logic        bind_d_r;
  logic        bind_rise;
  logic [2:0]  press_r;
  logic [11:0] win_r;
  logic        start_r;
  logic        fact_r;
  assign bind_rise = run & bind_s & ~bind_d_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bind_d_r <= 1'b0;
      press_r  <= 3'h0;
      win_r    <= 12'h000;
      start_r  <= 1'b0;
      fact_r   <= 1'b0;
    end else begin
      bind_d_r <= bind_s;
      start_r  <= bind_rise;
      fact_r   <= 1'b0;
      if (bind_rise) begin
        win_r <= 12'(`RCP_BIND_WIN_MS);
        if (press_r == 3'(`RCP_BIND_PRESSES - 1)) begin
          press_r <= 3'h0;
          fact_r  <= 1'b1;
        end else begin
          press_r <= press_r + 3'h1;
        end
      end else if (tick && win_r != 12'h000) begin
        win_r <= win_r - 12'h001;
        if (win_r == 12'h001) press_r <= 3'h0;
      end
    end
  end
  assign bind_start      = start_r;
  assign factory_default = fact_r;
  // -------------------------------------------------------------
  // activity indicator
  // -------------------------------------------------------------
  logic [9:0] ind_r;
  logic [9:0] on_ms;
  logic [1:0] state_f;
  logic       ind_q_r;
  assign state_f = ctrl_r[`RCP_CTRL_STATE_LSB +: 2];
  assign on_ms   = 10'(`RCP_IND_UNIT_MS) * ({8'h00, state_f} + 10'h001);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind_r   <= 10'h000;
      ind_q_r <= 1'b0;
    end else begin
      if (tick) begin
        if (ind_r == 10'(`RCP_IND_PERIOD_MS - 1)) ind_r <= 10'h000;
        else ind_r <= ind_r + 10'h001;
      end
      ind_q_r <= run & (ind_r < on_ms);
    end
  end
  assign activity_indicator = ind_q_r;
  // -------------------------------------------------------------
  // interrupt status
  // -------------------------------------------------------------
  logic [7:0]               lines_d_r;
  logic [`RCP_INT_W-1:0]    int_st_r;
  logic [`RCP_INT_W-1:0]    int_msk_r;
  logic [`RCP_INT_W-1:0]    int_set;
  logic [`RCP_INT_W-1:0]    int_clr;
  assign int_set = {fact_r, start_r, run & ack_match,
                    |((lines_s ^ lines_d_r) & in_mask)};
  // -------------------------------------------------------------
  // ahb-lite slave
  // -------------------------------------------------------------
  logic        ap_r;
  logic        ap_wr_r;
  logic [31:0] ap_addr_r;
  logic        take;
  logic        wr_dp;
  logic        rd_take;
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;
  assign take    = hsel & hready & htrans[1];
  assign wr_dp   = ap_r & ap_wr_r;
  assign rd_take = take & ~hwrite;
  assign int_clr = (wr_dp && ap_addr_r == `RCP_INTST_ADDR) ?
                   hwdata[`RCP_INT_W-1:0] : '0;
  assign rd_mux  =
    (haddr == `RCP_CTRL_ADDR)   ? ctrl_r :
    (haddr == `RCP_STAT_ADDR)   ? {24'h0000_00, 1'b0, reply_received,
                                   activity_indicator, run,
                                   straps.ack_en, straps.toggle_sel,
                                   straps.high_group_direction,
                                   straps.low_group_direction} :
    (haddr == `RCP_INTST_ADDR)  ? {28'h0000_000, int_st_r} :
    (haddr == `RCP_INTMSK_ADDR) ? {28'h0000_000, int_msk_r} :
    (haddr == `RCP_RXCMD_ADDR)  ? {24'h0000_00, out_r} :
    (haddr == `RCP_LINES_ADDR)  ? {24'h0000_00, lines_s & in_mask} :
    32'h0000_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r      <= 1'b0;
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 32'h0000_0000;
      rdata_r   <= 32'h0000_0000;
    end else begin
      ap_r    <= take;
      ap_wr_r <= take & hwrite;
      if (take) ap_addr_r <= haddr;
      if (rd_take) rdata_r <= rd_mux;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= `RCP_CTRL_RESET;
      int_msk_r <= '0;
      int_st_r  <= '0;
      lines_d_r <= 8'h00;
    end else begin
      lines_d_r <= lines_s;
      if (wr_dp && ap_addr_r == `RCP_CTRL_ADDR)   ctrl_r    <= hwdata;
      if (wr_dp && ap_addr_r == `RCP_INTMSK_ADDR)
        int_msk_r <= hwdata[`RCP_INT_W-1:0];
      int_st_r <= (int_st_r & ~int_clr) | int_set;
    end
  end
  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(int_st_r & int_msk_r);
endmodule

/* File: rcp_map.svh */
// constants of the remote control pin logic
`ifndef RCP_MAP_SVH
`define RCP_MAP_SVH
// register byte addresses
`define RCP_CTRL_ADDR    32'h0000_0000
`define RCP_STAT_ADDR    32'h0000_0004
`define RCP_INTST_ADDR   32'h0000_0008
`define RCP_INTMSK_ADDR  32'h0000_000C
`define RCP_RXCMD_ADDR   32'h0000_0010
`define RCP_LINES_ADDR   32'h0000_0014
// control register fields
`define RCP_CTRL_RX_BIT    0
`define RCP_CTRL_TX_BIT    1
`define RCP_CTRL_STATE_LSB 2
`define RCP_CTRL_RESET     32'h0000_0000
// interrupt status bits
`define RCP_INT_INCHG_BIT  0
`define RCP_INT_ACK_BIT    1
`define RCP_INT_BIND_BIT   2
`define RCP_INT_FACT_BIT   3
`define RCP_INT_W          4
// timing
`define RCP_CLK_HZ         50_000_000
`define RCP_TICK_HZ        1_000
`define RCP_TICK_DIV       (`RCP_CLK_HZ / `RCP_TICK_HZ)
`define RCP_ACK_HOLD_MS    100
`define RCP_ACK_TICKS      (`RCP_ACK_HOLD_MS * `RCP_TICK_HZ / 1000)
`define RCP_IND_UNIT_MS    50
`define RCP_IND_PERIOD_MS  1000
`define RCP_BIND_PRESSES   5
`define RCP_BIND_WIN_MS    3000
`endif

/* File: rcp_pkg.sv */
// types of the remote control pin logic
package rcp_pkg;
  typedef struct packed {
    logic [7:0] lines;
    logic       valid;
  } rcp_cmd_t;
  typedef struct packed {
    logic       ack_en;
    logic       toggle_sel;
    logic       low_group_direction;
    logic       high_group_direction;
  } rcp_straps_t;
endpackage

/* File: rcp_sync.sv */
// two flip-flop synchroniser for pin inputs
module rcp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* File: rcp_buttons.sv */
// button and contact model on the status lines
module rcp_buttons (
  // pin side
  input  wire logic [7:0] press,
  input  wire logic [7:0] status_lines_out,
  input  wire logic [7:0] status_lines_oe,
  output logic      [7:0] status_lines_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // released buttons fall to the pull-down level
  assign status_lines_in = (status_lines_oe & status_lines_out) |
                           (~status_lines_oe & press);
endmodule

/* File: rcp_top_assertions.sv */
// assertions on the ports of the pin control logic
module rcp_top_assertions
  import rcp_pkg::*;
(
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // pins
  input wire logic       reset_pin_n,
  input wire logic       sleep_req_n,
  input wire logic       low_group_direction,
  input wire logic       high_group_direction,
  input wire logic       ack_en,
  input wire logic       bind_req,
  input wire logic [7:0] status_lines_oe,
  input wire logic       receive_amp_enable,
  input wire logic       transmit_amp_enable,
  input wire logic       reply_received,
  input wire logic       reply_request,
  input wire logic       bind_start,
  // radio core side
  input wire logic [8:0] rx_cmd,
  input wire logic       ack_match
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_low_inputs: assert property (
    $past(low_group_direction, 2) && $past(low_group_direction, 3)
    |-> status_lines_oe[3:0] == 4'h0) else $error("low group driven");
  a_high_inputs: assert property (
    $past(high_group_direction, 2) && $past(high_group_direction, 3)
    |-> status_lines_oe[7:4] == 4'h0) else $error("high group driven");
  a_sleep_quiet: assert property (
    !$past(sleep_req_n, 3) && !$past(sleep_req_n, 4) |-> !status_lines_oe
    && !receive_amp_enable && !transmit_amp_enable) else $error("asleep");
  a_pin_reset: assert property (
    !$past(reset_pin_n, 3) && !$past(reset_pin_n, 4) |-> !status_lines_oe
    && !receive_amp_enable && !transmit_amp_enable) else $error("in reset");
  a_ack_hold: assert property (
    ack_match |=> reply_received [*8]) else $error("reply not held");
  a_reply_cause: assert property (
    reply_request |-> $past(rx_cmd[0]) && $past(ack_en, 3))
    else $error("reply without command");
  a_reply_off: assert property (
    !$past(ack_en, 3) && !$past(ack_en, 4) |-> !reply_request)
    else $error("reply while disabled");
  a_bind_start: assert property (
    $rose(bind_req) && sleep_req_n && reset_pin_n |-> ##[1:6] bind_start)
    else $error("bind not started");
  c_reply: cover property (reply_request);
  c_bind: cover property (bind_start);
  c_high_out: cover property (status_lines_oe == 8'hf0);
endmodule
bind rcp_top rcp_top_assertions chk_u (.hclk, .hresetn, .reset_pin_n,
  .sleep_req_n, .low_group_direction, .high_group_direction, .ack_en,
  .bind_req, .status_lines_oe, .receive_amp_enable, .transmit_amp_enable,
  .reply_received, .reply_request, .bind_start, .rx_cmd, .ack_match);

/* File: rcp_top_bench.sv */
// self-checking bench of the pin control logic
`include "rcp_map.svh"
module rcp_top_bench
  import rcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, v;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, irq, reset_pin_n = 1, sleep_req_n = 1;
  logic        low_group_direction = 0, high_group_direction = 1;
  logic        toggle_sel = 1, ack_en = 1, bind_req = 0, ack_match = 0;
  // radio command frames come from the send task; rx_cmd idles at zero
  logic [7:0]  press = '0, status_lines_in, status_lines_out;
  logic [7:0]  status_lines_oe;
  logic        receive_amp_enable, transmit_amp_enable, activity_indicator;
  logic        reply_received, reply_request, bind_start, factory_default;
  rcp_cmd_t    rx_cmd = '0;
  int          failures = 0, checked = 0, n_req = 0, n_bind = 0, n_fd = 0;
  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    if (reply_request === 1'b1) n_req++;
    if (bind_start === 1'b1) n_bind++;
    if (factory_default === 1'b1) n_fd++;
  end
  rcp_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq,
    .reset_pin_n, .sleep_req_n, .low_group_direction, .high_group_direction,
    .toggle_sel, .ack_en, .bind_req, .status_lines_in, .status_lines_out,
    .status_lines_oe, .receive_amp_enable, .transmit_amp_enable,
    .activity_indicator, .reply_received, .reply_request, .bind_start,
    .factory_default, .rx_cmd, .ack_match);
  rcp_buttons btn_u (.press, .status_lines_out, .status_lines_oe,
    .status_lines_in);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic xfer(logic wr, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    v = hrdata;
  endtask
  task automatic rd(string nm, logic [31:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, e, v);
    chk("resp", 32'h0000_0000, hresp);
  endtask
  task automatic send(logic [7:0] l);
    rx_cmd <= '{l, 1'b1};
    @(posedge hclk);
    rx_cmd <= '0;
    idle(3);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    idle(8);
    hresetn <= 1'b1;
    idle(4);
    rd("ctrl", `RCP_CTRL_ADDR, `RCP_CTRL_RESET);
    rd("hole", 32'h0000_0040, 32'h0000_0000);
    rd("stat", `RCP_STAT_ADDR, 32'h0000_003e);
    xfer(1'b1, `RCP_CTRL_ADDR, 32'h0000_0003);
    idle(2);
    chk("amps", 2'b11, {transmit_amp_enable, receive_amp_enable});
    chk("oe", 8'h0f, status_lines_oe);
    chk("ind", 1'b1, activity_indicator);
    send(8'hff);
    chk("tog1", 8'h0f, status_lines_out);
    send(8'hff);
    chk("tog2", 8'h00, status_lines_out);
    chk("req", 2, n_req);
    toggle_sel <= 1'b0;
    ack_en <= 1'b0;
    low_group_direction <= 1'b1;
    high_group_direction <= 1'b0;
    idle(5);
    chk("oe2", 8'hf0, status_lines_oe);
    send(8'ha5);
    chk("mom1", 8'ha0, status_lines_out);
    send(8'h00);
    chk("mom2", 8'h00, status_lines_out);
    chk("noreq", 2, n_req);
    press <= 8'h06;
    idle(5);
    rd("lines", `RCP_LINES_ADDR, 32'h0000_0006);
    xfer(1'b1, `RCP_INTMSK_ADDR, 32'h0000_0001);
    idle(1);
    chk("irq1", 1'b1, irq);
    xfer(1'b1, `RCP_INTST_ADDR, 32'h0000_0001);
    idle(1);
    chk("irq0", 1'b0, irq);
    ack_match <= 1'b1;
    @(posedge hclk);
    ack_match <= 1'b0;
    idle(100);
    chk("ack", 1'b1, reply_received);
    repeat (5) begin
      bind_req <= 1'b1;
      idle(6);
      bind_req <= 1'b0;
      idle(6);
    end
    chk("bind", 5, n_bind);
    chk("fdef", 1, n_fd);
    xfer(1'b1, `RCP_CTRL_ADDR, 32'h0000_0003);
    sleep_req_n <= 1'b0;
    idle(6);
    chk("sleep", 10'h000, {status_lines_oe, receive_amp_enable,
      transmit_amp_enable});
    sleep_req_n <= 1'b1;
    reset_pin_n <= 1'b0;
    idle(6);
    chk("rstpin", 10'h000, {status_lines_oe, receive_amp_enable,
      transmit_amp_enable});
    reset_pin_n <= 1'b1;
    idle(2);
    end_sim();
  end
endmodule
